// ===== core/smsq_map.svh
/*
 Offsets, bit positions and status codes for the SMBus master sequencer.
 Assumes it is included by bare name from the sequencer design file.
*/
`ifndef SMSQ_MAP_SVH
`define SMSQ_MAP_SVH

// Device register port
`define SMSQ_DEV_CTRL 8'h00
`define SMSQ_DEV_DATA 8'h01

// Bus control register bits
`define SMSQ_CB_MASTER 7
`define SMSQ_CB_TRANSMIT_DIRECTION_BIT 6
`define SMSQ_CB_STA 5
`define SMSQ_CB_STO 4
`define SMSQ_CB_ACKNOWLEDGE_REQUEST_FLAG 3
`define SMSQ_CB_ARBITRATION_LOSS_FLAG 2
`define SMSQ_CB_ACK 1
`define SMSQ_CB_SI 0
`define SMSQ_CB_VEC_HI 7
`define SMSQ_CB_VEC_LO 4

// Status vectors
`define SMSQ_SV_START 4'hE
`define SMSQ_SV_TXDONE 4'hC
`define SMSQ_SV_RXDONE 4'h8

// Host register offsets
`define SMSQ_H_CMD 8'h00
`define SMSQ_H_ADDR 8'h04
`define SMSQ_H_COUNT 8'h08
`define SMSQ_H_MODE 8'h0C
`define SMSQ_H_TXDATA 8'h10
`define SMSQ_H_RXDATA 8'h14
`define SMSQ_H_STATUS 8'h18

// Host command, mode and status bits
`define SMSQ_CMD_GO 0
`define SMSQ_CMD_CLRERR 1
`define SMSQ_MODE_LASTACK 2
`define SMSQ_ST_BUSY 0
`define SMSQ_ST_GOPEND 1
`define SMSQ_ST_NACKERR 2
`define SMSQ_ST_SCLLOW 3
`define SMSQ_ST_TXFULL 4
`define SMSQ_ST_RXVALID 5
`define SMSQ_ST_HOLD 6
`define SMSQ_ST_VEC_HI 11
`define SMSQ_ST_VEC_LO 8

// Buffers
`define SMSQ_FIFO_DEPTH 4
`define SMSQ_BYTE_W 8

`endif

// ===== core/smsq_pkg.sv
/*
 Types shared by the SMBus master sequencer.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package smsq_pkg;
   typedef enum logic [2:0] {S_IDLE, S_RDREQ, S_RDA, S_RDDATA, S_DECIDE, S_WRDATA, S_CTRL} smsq_state_t;
   typedef enum logic [1:0] {END_STOP, END_STOPSTART, END_RESTART, END_SWITCH} smsq_end_t;
endpackage

// ===== core/smsq_ctrl.sv
/*
 SMBus master sequencer: drives an SMBus master peripheral through its
 control and data registers, reacting to each status vector, plus two small
 byte FIFOs, one for transmit data and one for receive data.
 Assumes the peripheral register port answers a read one cycle later and
 holds the bus clock low while its event flag is set.
*/
// Overview of operation
// - After START (1110) load address plus direction; 1100 follows.
// - In 1100, begin request alone gives repeated START; 1110 follows.
// - In 1100 after NACK, end request alone aborts with STOP.
// - In 1100 after ACK, load next byte, no requests; 1100 follows.
// - In 1100 after ACK, end request alone finishes with STOP.
// - In 1100 after ACK, both requests give STOP then START.
// - In 1100 after ACK, clear event flag only; receive, 1000 follows.
// - In 1000, acknowledge set, no requests, read data; 1000 recurs.
// - In 1000, NACK with end request finishes with STOP.
// - In 1000, NACK with both requests gives STOP then START.
// - In 1000, ACK with begin request gives repeated START.
// - In 1000, NACK with begin request gives repeated START.
// - In 1000, write data before clearing flag with ACK: transmit next.
// - In 1000, write data before clearing flag with NACK: transmit next.
`timescale 1ns/10ps
`include "smsq_map.svh"

module smsq_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Fill side
   input wire logic [WIDTH-1:0] inData,
   input wire logic inValid,
   output logic inReady,
   // Drain side
   output logic [WIDTH-1:0] outData,
   output logic outValid,
   input wire logic outReady
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr_r;
   logic [AW-1:0] rdPtr_r;
   logic [AW:0] count_r;
   logic push;
   logic pop;

   assign inReady = count_r != FULL;
   assign outValid = count_r != '0;
   assign outData = mem[rdPtr_r];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr_r] <= inData;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
      end else begin
         if (push) begin
            wrPtr_r <= (wrPtr_r == LAST) ? '0 : wrPtr_r + 1'b1;
         end
         if (pop) begin
            rdPtr_r <= (rdPtr_r == LAST) ? '0 : rdPtr_r + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         count_r <= '0;
      end else if (push && !pop) begin
         count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
         count_r <= count_r - 1'b1;
      end
   end

   a_fifo_no_overflow: assert property (@(posedge clk) disable iff (!rst_n) count_r <= FULL)
      else $error("fifo count above depth");
endmodule

module smsq_ctrl
   import smsq_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Host register port
   input wire logic [7:0] hostAddr,
   input wire logic [31:0] hostWdata,
   input wire logic hostWr,
   input wire logic hostRd,
   output logic [31:0] hostRdata,
   // Peripheral register port
   output logic [7:0] devAddr,
   output logic [7:0] devWdata,
   output logic devWr,
   output logic devRd,
   input wire logic [7:0] devRdata,
   // Bus clock pin, observed only
   input wire logic sclIn
);
   smsq_state_t state_r;
   smsq_end_t mode_r;
   logic lastAck_r;
   logic [7:0] addr_r;
   logic [7:0] count_r;
   logic [7:0] remain_r;
   logic readDir_r;
   logic goPend_r;
   logic nackErr_r;
   logic [3:0] vector_r;
   logic ackIn_r;
   logic [7:0] ctrlNext_r;
   logic [7:0] dataByte_r;
   logic wantData_r;
   logic rdIsData_r;
   logic [7:0] devAddr_r;
   logic [7:0] devWdata_r;
   logic devWr_r;
   logic devRd_r;
   logic [31:0] hostRdata_r;
   logic sclMeta_r;
   logic sclSync_r;
   // Decision outputs
   smsq_state_t dNext;
   logic [7:0] dCtrl;
   logic [7:0] dData;
   logic dWantData;
   logic dTxTake;
   logic dRxRead;
   logic dErr;
   logic dAddrTake;
   logic dSwitch;
   logic dRemainDec;
   logic lastByte;
   logic holding;
   // FIFO wiring
   logic txPush;
   logic txInReady;
   logic [7:0] txData;
   logic txValid;
   logic rxPush;
   logic rxInReady;
   logic [7:0] rxData;
   logic rxValid;
   logic rxPop;
   logic goWrite;
   logic clrErrWrite;

   function automatic logic isReg(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction

   function automatic logic [7:0] ctrlByte(input logic begin_condition_request, input logic end_condition_request, input logic ack);
      logic [7:0] b;
      b = 8'h00;
      b[`SMSQ_CB_STA] = begin_condition_request;
      b[`SMSQ_CB_STO] = end_condition_request;
      b[`SMSQ_CB_ACK] = ack;
      return b;
   endfunction

   assign devAddr = devAddr_r;
   assign devWdata = devWdata_r;
   assign devWr = devWr_r;
   assign devRd = devRd_r;
   assign hostRdata = hostRdata_r;

   assign txPush = hostWr && isReg(hostAddr, `SMSQ_H_TXDATA);
   assign rxPop = hostRd && isReg(hostAddr, `SMSQ_H_RXDATA);
   assign rxPush = (state_r == S_RDDATA) && rdIsData_r;
   assign goWrite = hostWr && isReg(hostAddr, `SMSQ_H_CMD) && hostWdata[`SMSQ_CMD_GO];
   assign clrErrWrite = hostWr && isReg(hostAddr, `SMSQ_H_CMD) && hostWdata[`SMSQ_CMD_CLRERR];
   assign lastByte = remain_r <= 8'h01;
   // Waiting at a fresh START for the next job; the peripheral keeps the clock low
   assign holding = (state_r == S_DECIDE) && (vector_r == `SMSQ_SV_START) && !goPend_r;

   smsq_fifo #(.WIDTH(`SMSQ_BYTE_W), .DEPTH(`SMSQ_FIFO_DEPTH)) txFifo (
      .clk(clk),
      .rst_n(rst_n),
      .inData(hostWdata[7:0]),
      .inValid(txPush),
      .inReady(txInReady),
      .outData(txData),
      .outValid(txValid),
      .outReady(dTxTake)
   );

   smsq_fifo #(.WIDTH(`SMSQ_BYTE_W), .DEPTH(`SMSQ_FIFO_DEPTH)) rxFifo (
      .clk(clk),
      .rst_n(rst_n),
      .inData(devRdata),
      .inValid(rxPush),
      .inReady(rxInReady),
      .outData(rxData),
      .outValid(rxValid),
      .outReady(rxPop)
   );

   // Bus clock pin seen through two flops
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sclMeta_r <= 1'b1;
         sclSync_r <= 1'b1;
      end else begin
         sclMeta_r <= sclIn;
         sclSync_r <= sclMeta_r;
      end
   end

   // Host configuration
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         addr_r <= 8'h00;
         count_r <= 8'h00;
         mode_r <= END_STOP;
         lastAck_r <= 1'b0;
      end else if (hostWr) begin
         if (isReg(hostAddr, `SMSQ_H_ADDR)) begin
            addr_r <= hostWdata[7:0];
         end
         if (isReg(hostAddr, `SMSQ_H_COUNT)) begin
            count_r <= hostWdata[7:0];
         end
         if (isReg(hostAddr, `SMSQ_H_MODE)) begin
            mode_r <= smsq_end_t'(hostWdata[1:0]);
            lastAck_r <= hostWdata[`SMSQ_MODE_LASTACK];
         end
      end
   end

   // Sticky flags; a set in the same cycle as a clear wins
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         goPend_r <= 1'b0;
         nackErr_r <= 1'b0;
      end else begin
         goPend_r <= goWrite || (goPend_r && !dAddrTake);
         nackErr_r <= dErr || (nackErr_r && !clrErrWrite);
      end
   end

   // Host read data, one cycle after the strobe
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         hostRdata_r <= 32'h0000_0000;
      end else if (hostRd) begin
         hostRdata_r <= 32'h0000_0000;
         if (isReg(hostAddr, `SMSQ_H_RXDATA)) begin
            hostRdata_r[7:0] <= rxData;
         end else if (isReg(hostAddr, `SMSQ_H_COUNT)) begin
            hostRdata_r[7:0] <= count_r;
         end else if (isReg(hostAddr, `SMSQ_H_ADDR)) begin
            hostRdata_r[7:0] <= addr_r;
         end else if (isReg(hostAddr, `SMSQ_H_STATUS)) begin
            hostRdata_r[`SMSQ_ST_BUSY] <= state_r != S_IDLE;
            hostRdata_r[`SMSQ_ST_GOPEND] <= goPend_r;
            hostRdata_r[`SMSQ_ST_NACKERR] <= nackErr_r;
            hostRdata_r[`SMSQ_ST_SCLLOW] <= !sclSync_r;
            hostRdata_r[`SMSQ_ST_TXFULL] <= !txInReady;
            hostRdata_r[`SMSQ_ST_RXVALID] <= rxValid;
            hostRdata_r[`SMSQ_ST_HOLD] <= holding;
            hostRdata_r[`SMSQ_ST_VEC_HI:`SMSQ_ST_VEC_LO] <= vector_r;
         end
      end
   end

   // Reaction to a status vector; stalls in S_DECIDE while a FIFO is not ready
   always_comb begin
      dNext = S_DECIDE;
      dCtrl = 8'h00;
      dData = 8'h00;
      dWantData = 1'b0;
      dTxTake = 1'b0;
      dRxRead = 1'b0;
      dErr = 1'b0;
      dAddrTake = 1'b0;
      dSwitch = 1'b0;
      dRemainDec = 1'b0;
      if (state_r == S_DECIDE) begin
         case (vector_r)
            `SMSQ_SV_START: begin
               if (goPend_r) begin
                  dAddrTake = 1'b1;
                  dData = addr_r;
                  dWantData = 1'b1;
                  dNext = S_WRDATA;
               end
            end
            `SMSQ_SV_TXDONE: begin
               if (!ackIn_r) begin
                  dErr = 1'b1;
                  dNext = S_CTRL;
                  if (mode_r == END_RESTART) begin
                     dCtrl = ctrlByte(1'b1, 1'b0, 1'b0);
                  end else begin
                     dCtrl = ctrlByte(1'b0, 1'b1, 1'b0);
                  end
               end else if (readDir_r) begin
                  dNext = S_CTRL;
               end else if (remain_r != 8'h00) begin
                  if (txValid) begin
                     dTxTake = 1'b1;
                     dData = txData;
                     dWantData = 1'b1;
                     dRemainDec = 1'b1;
                     dNext = S_WRDATA;
                  end
               end else begin
                  dNext = S_CTRL;
                  case (mode_r)
                     END_STOPSTART: dCtrl = ctrlByte(1'b1, 1'b1, 1'b0);
                     END_RESTART: dCtrl = ctrlByte(1'b1, 1'b0, 1'b0);
                     default: dCtrl = ctrlByte(1'b0, 1'b1, 1'b0);
                  endcase
               end
            end
            `SMSQ_SV_RXDONE: begin
               if (rxInReady && !(lastByte && mode_r == END_SWITCH && !txValid)) begin
                  dRxRead = 1'b1;
                  dRemainDec = 1'b1;
                  dNext = S_RDREQ;
                  if (!lastByte) begin
                     dCtrl = ctrlByte(1'b0, 1'b0, 1'b1);
                  end else begin
                     case (mode_r)
                        END_STOPSTART: dCtrl = ctrlByte(1'b1, 1'b1, 1'b0);
                        END_RESTART: dCtrl = ctrlByte(1'b1, 1'b0, lastAck_r);
                        END_SWITCH: begin
                           // Data goes in before the flag is cleared
                           dTxTake = 1'b1;
                           dData = txData;
                           dWantData = 1'b1;
                           dSwitch = 1'b1;
                           dCtrl = ctrlByte(1'b0, 1'b0, lastAck_r);
                        end
                        default: dCtrl = ctrlByte(1'b0, 1'b1, 1'b0);
                     endcase
                  end
               end
            end
            default: begin
               // Unexpected vector (slave mode or lost arbitration): release the bus
               dErr = 1'b1;
               dCtrl = ctrlByte(1'b0, 1'b1, 1'b0);
               dNext = S_CTRL;
            end
         endcase
      end
   end

   // Transfer bookkeeping
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         remain_r <= 8'h00;
         readDir_r <= 1'b0;
      end else if (dAddrTake) begin
         remain_r <= count_r;
         readDir_r <= addr_r[0];
      end else begin
         if (dRemainDec && remain_r != 8'h00) begin
            remain_r <= remain_r - 8'h01;
         end
         if (dSwitch) begin
            readDir_r <= 1'b0;
         end
      end
   end

   // Sequencer and peripheral register accesses
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_r <= S_IDLE;
         devAddr_r <= 8'h00;
         devWdata_r <= 8'h00;
         devWr_r <= 1'b0;
         devRd_r <= 1'b0;
         vector_r <= 4'h0;
         ackIn_r <= 1'b0;
         ctrlNext_r <= 8'h00;
         dataByte_r <= 8'h00;
         wantData_r <= 1'b0;
         rdIsData_r <= 1'b0;
      end else begin
         devWr_r <= 1'b0;
         devRd_r <= 1'b0;
         case (state_r)
            S_IDLE: begin
               if (goPend_r) begin
                  devWr_r <= 1'b1;
                  devAddr_r <= `SMSQ_DEV_CTRL;
                  devWdata_r <= ctrlByte(1'b1, 1'b0, 1'b0);
                  rdIsData_r <= 1'b0;
                  state_r <= S_RDREQ;
               end
            end
            S_RDREQ: begin
               devRd_r <= 1'b1;
               devAddr_r <= rdIsData_r ? `SMSQ_DEV_DATA : `SMSQ_DEV_CTRL;
               state_r <= S_RDA;
            end
            S_RDA: state_r <= S_RDDATA;
            S_RDDATA: begin
               if (rdIsData_r) begin
                  state_r <= wantData_r ? S_WRDATA : S_CTRL;
               end else if (devRdata[`SMSQ_CB_SI]) begin
                  vector_r <= devRdata[`SMSQ_CB_VEC_HI:`SMSQ_CB_VEC_LO];
                  ackIn_r <= devRdata[`SMSQ_CB_ACK];
                  state_r <= S_DECIDE;
               end else begin
                  state_r <= S_RDREQ;
               end
            end
            S_DECIDE: begin
               state_r <= dNext;
               if (dNext != S_DECIDE) begin
                  ctrlNext_r <= dCtrl;
                  dataByte_r <= dData;
                  wantData_r <= dWantData;
                  rdIsData_r <= dRxRead;
               end
            end
            S_WRDATA: begin
               devWr_r <= 1'b1;
               devAddr_r <= `SMSQ_DEV_DATA;
               devWdata_r <= dataByte_r;
               state_r <= S_CTRL;
            end
            S_CTRL: begin
               // Event flag written as zero: the peripheral acts only now
               devWr_r <= 1'b1;
               devAddr_r <= `SMSQ_DEV_CTRL;
               devWdata_r <= ctrlNext_r;
               rdIsData_r <= 1'b0;
               wantData_r <= 1'b0;
               if (ctrlNext_r[`SMSQ_CB_STO] && !ctrlNext_r[`SMSQ_CB_STA]) begin
                  state_r <= S_IDLE;
               end else begin
                  state_r <= S_RDREQ;
               end
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end

   a_dev_strobes_apart: assert property (@(posedge clk) disable iff (!rst_n) !(devWr_r && devRd_r))
      else $error("peripheral read and write together");
   a_start_addr_load: assert property (@(posedge clk) disable iff (!rst_n)
      (state_r == S_DECIDE && vector_r == `SMSQ_SV_START && goPend_r) |->
      ##2 (devWr_r && devAddr_r == `SMSQ_DEV_DATA && devWdata_r == $past(addr_r, 2)))
      else $error("address not loaded after start");
   a_nack_restart: assert property (@(posedge clk) disable iff (!rst_n)
      (state_r == S_DECIDE && vector_r == `SMSQ_SV_TXDONE && !ackIn_r && mode_r == END_RESTART) |->
      ##2 (devWr_r && devWdata_r == ctrlByte(1'b1, 1'b0, 1'b0) && state_r == S_RDREQ))
      else $error("no repeated start after nack");
   a_nack_abort_stop: assert property (@(posedge clk) disable iff (!rst_n)
      (state_r == S_DECIDE && vector_r == `SMSQ_SV_TXDONE && !ackIn_r && mode_r != END_RESTART) |->
      ##2 (devWr_r && devWdata_r == ctrlByte(1'b0, 1'b1, 1'b0) && state_r == S_IDLE))
      else $error("no stop after nack abort");
   a_tx_next_byte: assert property (@(posedge clk) disable iff (!rst_n)
      (state_r == S_DECIDE && vector_r == `SMSQ_SV_TXDONE && ackIn_r && !readDir_r && remain_r != 8'h00
      && txValid) |-> ##2 (devWr_r && devAddr_r == `SMSQ_DEV_DATA) ##1 (devWr_r && devWdata_r == 8'h00))
      else $error("next byte not sent");
   a_tx_end_stop: assert property (@(posedge clk) disable iff (!rst_n)
      (state_r == S_DECIDE && vector_r == `SMSQ_SV_TXDONE && ackIn_r && !readDir_r && remain_r == 8'h00
      && mode_r == END_STOP) |-> ##2 (devWr_r && devWdata_r == ctrlByte(1'b0, 1'b1, 1'b0)))
      else $error("transfer not ended with stop");
   a_tx_stop_start: assert property (@(posedge clk) disable iff (!rst_n)
      (state_r == S_DECIDE && vector_r == `SMSQ_SV_TXDONE && ackIn_r && !readDir_r && remain_r == 8'h00
      && mode_r == END_STOPSTART) |-> ##2 (devWr_r && devWdata_r == ctrlByte(1'b1, 1'b1, 1'b0)))
      else $error("stop and start not requested");
   a_switch_to_rx: assert property (@(posedge clk) disable iff (!rst_n)
      (state_r == S_DECIDE && vector_r == `SMSQ_SV_TXDONE && ackIn_r && readDir_r) |->
      ##2 (devWr_r && devAddr_r == `SMSQ_DEV_CTRL && devWdata_r == 8'h00))
      else $error("flag not cleared for receive");
   a_rx_ack_more: assert property (@(posedge clk) disable iff (!rst_n)
      (state_r == S_DECIDE && vector_r == `SMSQ_SV_RXDONE && rxInReady && !lastByte) |->
      ##2 (devRd_r && devAddr_r == `SMSQ_DEV_DATA) ##3 (devWr_r && devWdata_r == ctrlByte(1'b0, 1'b0, 1'b1)))
      else $error("received byte not acknowledged");
   a_rx_last_stop: assert property (@(posedge clk) disable iff (!rst_n)
      (state_r == S_DECIDE && vector_r == `SMSQ_SV_RXDONE && rxInReady && lastByte && mode_r == END_STOP) |->
      ##5 (devWr_r && devWdata_r == ctrlByte(1'b0, 1'b1, 1'b0) && state_r == S_IDLE))
      else $error("last byte not nacked with stop");
endmodule

// ===== bench/smsq_dev_model.sv
/*
 Model of the SMBus master peripheral and its slave, seen through its register port.
 Assumes one access per strobe; logs each START, STOP, byte sent and acknowledge given.
*/
`timescale 1ns/10ps
module smsq_dev_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register port
   input wire logic [7:0] devAddr,
   input wire logic [7:0] devWdata,
   input wire logic devWr,
   input wire logic devRd,
   output logic [7:0] devRdata,
   output logic sclOut,
   // Bench controls
   input wire logic slow,
   input wire logic nack
);
   logic [3:0] vec, nv;
   logic [7:0] dat, rxByte, rdd;
   logic [5:0] cnt;
   logic si, ackBit, dataNew, rdv, begin_condition_request, end_condition_request;
   logic [11:0] evLog[$];
   // Bus clock held low while the flag is set
   assign sclOut = si ? 1'b0 : (cnt != 6'h0 ? cnt[2] : 1'b1);
   // Released port shows the inverse, so a late sample cannot pass by luck
   assign devRdata = rdv ? rdd : ~rdd;
   always @(posedge clk) begin
      rdv <= devRd && rst_n;
      if (devRd) rdd <= (devAddr == 8'h01) ? rxByte : {vec, vec == 4'h8, 1'b0, ackBit, si};
   end
   always @(posedge clk) begin
      if (!rst_n) begin
         vec <= 4'h0;
         si <= 1'b0;
         cnt <= 6'h0;
         dataNew <= 1'b0;
         rxByte <= 8'h50;
         ackBit <= 1'b0;
      end else begin
         if (cnt == 6'h1) si <= 1'b1;
         if (cnt != 6'h0) cnt <= cnt - 6'h1;
         if (devWr && devAddr == 8'h01) begin
            dat <= devWdata;
            dataNew <= 1'b1;
         end
         // Requests act only on the write that clears the flag
         if (devWr && devAddr == 8'h00 && !devWdata[0]) begin
            begin_condition_request = devWdata[5];
            end_condition_request = devWdata[4];
            si <= 1'b0;
            dataNew <= 1'b0;
            cnt <= slow ? 6'h28 : 6'h4;
            if (vec == 4'h8) begin
               evLog.push_back({devWdata[1] ? 4'h4 : 4'h5, rxByte});
               rxByte <= rxByte + 8'h1;
            end
            if (end_condition_request && vec != 4'h0) evLog.push_back(12'h200);
            if (begin_condition_request) begin
               evLog.push_back(12'h100);
               nv = 4'hE;
            end else if (end_condition_request) begin
               nv = 4'h0;
            end else if (vec == 4'hE || dataNew) begin
               evLog.push_back({4'h3, dat});
               ackBit <= !nack;
               nv = 4'hC;
            end else begin
               nv = (vec == 4'h0) ? 4'h0 : 4'h8;
            end
            vec <= nv;
            if (nv == 4'h0) cnt <= 6'h0;
         end
      end
   end
endmodule

// ===== bench/test_smsq_ctrl.sv
/*
 Testbench for the SMBus master sequencer: host register tasks, bus event log checks.
 Assumes the device model logs events as {kind, byte}: 1 start, 2 stop, 3 sent, 4 ack, 5 nack.
*/
`timescale 1ns/10ps
module test_smsq_ctrl;
   logic clk = 0, rst_n = 0, hostWr = 0, hostRd = 0, slow = 0, nack = 0;
   logic [7:0] hostAddr = 8'h00, devAddr, devWdata, devRdata;
   logic [31:0] hostWdata = 32'h0, hostRdata, rd;
   logic devWr, devRd, sclIn;
   logic [11:0] exp[$];
   int num_errors = 0, n_checks = 0, cyc = 0, base = 0;
   always #10 clk = ~clk;
   smsq_ctrl i_dut (.clk(clk), .rst_n(rst_n), .hostAddr(hostAddr), .hostWdata(hostWdata), .hostWr(hostWr),
      .hostRd(hostRd), .hostRdata(hostRdata), .devAddr(devAddr), .devWdata(devWdata), .devWr(devWr),
      .devRd(devRd), .devRdata(devRdata), .sclIn(sclIn));
   smsq_dev_model i_dev (.clk(clk), .rst_n(rst_n), .devAddr(devAddr), .devWdata(devWdata), .devWr(devWr),
      .devRd(devRd), .devRdata(devRdata), .sclOut(sclIn), .slow(slow), .nack(nack));
   task automatic conclude;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(string what, logic [31:0] e, logic [31:0] s);
      n_checks++;
      if (s !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, e, s);
      end
   endtask
   // Strobe stays high across back-to-back writes; the next read lowers it
   task automatic wr(logic [7:0] a, logic [31:0] d);
      hostAddr <= a;
      hostWdata <= d;
      hostWr <= 1'b1;
      @(posedge clk);
   endtask
   task automatic rdh(logic [7:0] a);
      hostWr <= 1'b0;
      hostAddr <= a;
      hostRd <= 1'b1;
      @(posedge clk);
      hostRd <= 1'b0;
      #1 rd = hostRdata;
      @(posedge clk);
   endtask
   task automatic go(logic [7:0] a, logic [7:0] n, logic [2:0] m);
      wr(8'h04, {24'h0, a});
      wr(8'h08, {24'h0, n});
      wr(8'h0C, {29'h0, m});
      wr(8'h00, 32'h1);
   endtask
   // Waits until idle or parked at a START awaiting a new go
   task automatic wt;
      hostWr <= 1'b0;
      repeat (3) @(posedge clk);
      do rdh(8'h18); while ((rd[0] === 1'b1 || rd[1] === 1'b1) && rd[6] !== 1'b1);
   endtask
   task automatic cmpLog;
      chk("event count", exp.size(), i_dev.evLog.size() - base);
      foreach (exp[i]) chk("bus event", {20'h0, exp[i]}, {20'h0, i_dev.evLog[base + i]});
      base = i_dev.evLog.size();
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         num_errors++;
         conclude();
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      rdh(8'h18);
      chk("status after reset", 32'h0, rd);
      for (int i = 1; i <= 5; i++) wr(8'h10, 32'h11 * i);
      rdh(8'h18);
      chk("tx full", 32'h1, {31'h0, rd[4]});
      slow <= 1'b1;
      go(8'hA0, 8'h4, 3'h0);
      wt();
      exp = {12'h100, 12'h3A0, 12'h311, 12'h322, 12'h333, 12'h344, 12'h200};
      cmpLog();
      slow <= 1'b0;
      go(8'hA1, 8'h5, 3'h0);
      for (int i = 0; i < 5; i++) begin
         do rdh(8'h18); while (rd[5] !== 1'b1);
         rdh(8'h14);
         chk("rx byte", 32'h50 + i, rd);
      end
      wt();
      exp = {12'h100, 12'h3A1, 12'h450, 12'h451, 12'h452, 12'h453, 12'h554, 12'h200};
      cmpLog();
      wr(8'h10, 32'h66);
      go(8'hA0, 8'h1, 3'h1);
      wt();
      chk("vector and hold", 32'h1D, {27'h0, rd[11:8], rd[6]});
      exp = {12'h100, 12'h3A0, 12'h366, 12'h200, 12'h100};
      cmpLog();
      wr(8'h10, 32'h77);
      go(8'hA0, 8'h1, 3'h2);
      wt();
      exp = {12'h3A0, 12'h377, 12'h100};
      cmpLog();
      go(8'hA1, 8'h1, 3'h1);
      wt();
      exp = {12'h3A1, 12'h555, 12'h200, 12'h100};
      cmpLog();
      // Drain each single received byte so the receive buffer never fills and stalls a later read
      rdh(8'h14);
      chk("rx byte", 32'h55, rd);
      go(8'hA1, 8'h1, 3'h2);
      wt();
      exp = {12'h3A1, 12'h556, 12'h100};
      cmpLog();
      rdh(8'h14);
      chk("rx byte", 32'h56, rd);
      go(8'hA1, 8'h1, 3'h6);
      wt();
      exp = {12'h3A1, 12'h457, 12'h100};
      cmpLog();
      rdh(8'h14);
      chk("rx byte", 32'h57, rd);
      wr(8'h10, 32'h88);
      go(8'hA1, 8'h1, 3'h7);
      wt();
      exp = {12'h3A1, 12'h458, 12'h388, 12'h200};
      cmpLog();
      rdh(8'h14);
      chk("rx byte", 32'h58, rd);
      wr(8'h10, 32'h99);
      go(8'hA1, 8'h1, 3'h3);
      wt();
      exp = {12'h100, 12'h3A1, 12'h559, 12'h399, 12'h200};
      cmpLog();
      rdh(8'h14);
      chk("rx byte", 32'h59, rd);
      nack <= 1'b1;
      // Refused address in restart mode: repeated START, then parked for the next job
      go(8'hA0, 8'h1, 3'h2);
      wt();
      exp = {12'h100, 12'h3A0, 12'h100};
      cmpLog();
      chk("restart after nack hold", 32'h1, {31'h0, rd[6]});
      go(8'hA0, 8'h1, 3'h0);
      wt();
      exp = {12'h3A0, 12'h200};
      cmpLog();
      chk("nack error set", 32'h1, {31'h0, rd[2]});
      wr(8'h00, 32'h2);
      rdh(8'h18);
      chk("nack error cleared", 32'h0, {31'h0, rd[2]});
      conclude();
   end
endmodule
